// >>> hskc_defines.vh
// constants for the host serial and key control block
`ifndef HSKC_DEFINES_VH
`define HSKC_DEFINES_VH
`define HSKC_CLK_HZ        40000000
`define HSKC_A_CTRL        12'h000
`define HSKC_A_BAUD        12'h004
`define HSKC_A_STATUS      12'h008
`define HSKC_A_TXDATA      12'h00c
`define HSKC_A_RXDATA      12'h010
`define HSKC_A_STATE       12'h014
`define HSKC_CTRL_FLOW     0
`define HSKC_CTRL_PAR_LO   1
`define HSKC_CTRL_PAR_HI   2
`define HSKC_CTRL_STOP2    3
`define HSKC_CTRL_RESET    4'h0
`define HSKC_PAR_NONE      2'h0
`define HSKC_PAR_ODD       2'h1
`define HSKC_PAR_EVEN      2'h2
`define HSKC_BAUD_STD      9600
`define HSKC_BAUD_MIN      2400
`define HSKC_BAUD_MAX      115200
`define HSKC_DIV_STD       16'd4167
`define HSKC_DIV_MIN       16'd347
`define HSKC_DIV_MAX       16'd16667
`define HSKC_ST_STANDBY    2'h0
`define HSKC_ST_CONNECTED  2'h1
`define HSKC_ST_LOWPOWER   2'h2
`define HSKC_ST_HIBERNATE  2'h3
`define HSKC_KEY_LONG_MS   200
`define HSKC_KEY_PAIR_MS   100
`define HSKC_BLINK_ON_MS   1000
`define HSKC_BLINK_OFF_MS  1000
`define HSKC_CONN_ON_MS    3000
`define HSKC_CONN_OFF_MS   50
`define HSKC_MS_CYC        (`HSKC_CLK_HZ / 1000)
`endif

// >>> hskc_top.v
// host serial link, key pin decoding and status pin of the wireless module
// Functional notes
// - key low 200ms then release: disconnect or wake
// - standby key low 100ms enters pairing
// - pairing mode lets central connect automatically
// - separate independent receive and transmit lines
// - rts/cts active low, optionally disabled
// - baud 2400 to 115200, 9600 default
// - 8 data bits, parity, one/two stops
// - status pin blink patterns per state; held low in low power and hibernate
//
// Design decisions made here: the register addresses and register access over APB.
`include "hskc_defines.vh"
module hskc_top #(
  parameter MS_CYC = `HSKC_MS_CYC
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial pins
  input  wire        uart_rx,
  output reg         uart_tx,
  input  wire        cts_n,
  output reg         rts_n,
  // key pin and radio link events
  input  wire        key_n,
  input  wire        link_up,
  input  wire        link_down,
  input  wire        lowpower_req,
  input  wire        hibernate_req,
  output reg         disconnect_req,
  output reg         pairing,
  output reg         work_status
);
  localparam [31:0] KEY_LONG = `HSKC_KEY_LONG_MS * MS_CYC;
  localparam [31:0] KEY_PAIR = `HSKC_KEY_PAIR_MS * MS_CYC;
  localparam [31:0] BL_ON    = `HSKC_BLINK_ON_MS * MS_CYC;
  localparam [31:0] BL_OFF   = `HSKC_BLINK_OFF_MS * MS_CYC;
  localparam [31:0] CN_ON    = `HSKC_CONN_ON_MS * MS_CYC;
  localparam [31:0] CN_OFF   = `HSKC_CONN_OFF_MS * MS_CYC;
  // serial engine states
  localparam [2:0] S_IDLE = 3'd0, S_START = 3'd1, S_DATA = 3'd2, S_PAR = 3'd3, S_STOP = 3'd4;

  // pin synchronisers
  reg [1:0] rx_s, cts_s, key_s;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s  <= 2'b11;
      cts_s <= 2'b11;
      key_s <= 2'b11;
    end else begin
      rx_s  <= {rx_s[0], uart_rx};
      cts_s <= {cts_s[0], cts_n};
      key_s <= {key_s[0], key_n};
    end
  end
  wire rx_i  = rx_s[1];
  wire cts_i = cts_s[1];
  wire key_i = key_s[1];

  // configuration registers
  reg [3:0]  ctrl;
  reg [15:0] div;
  wire       flow_en = ctrl[`HSKC_CTRL_FLOW];
  wire [1:0] par     = ctrl[`HSKC_CTRL_PAR_HI:`HSKC_CTRL_PAR_LO];
  wire       stop2   = ctrl[`HSKC_CTRL_STOP2];

  function parity_bit;
    input [1:0] mode;
    input [7:0] d;
    begin
      parity_bit = (mode == `HSKC_PAR_ODD) ? ~(^d) : (^d);
    end
  endfunction

  // transmitter
  reg [2:0]  tx_st;
  reg [15:0] tx_cnt;
  reg [2:0]  tx_bit;
  reg        tx_stop2nd;
  reg [7:0]  tx_sh;
  reg        tx_full;
  reg [7:0]  tx_hold;
  wire       tx_tick = (tx_cnt == 16'd0);
  wire       tx_wr;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st      <= S_IDLE;
      tx_cnt     <= 16'd0;
      tx_bit     <= 3'd0;
      tx_stop2nd <= 1'b0;
      tx_sh      <= 8'h00;
      tx_full    <= 1'b0;
      tx_hold    <= 8'h00;
      uart_tx    <= 1'b1;
    end else begin
      if (tx_wr) begin
        tx_full <= 1'b1;
        tx_hold <= pwdata[7:0];
      end
      tx_cnt <= tx_tick ? div - 16'd1 : tx_cnt - 16'd1;
      case (tx_st)
        S_IDLE: begin
          uart_tx <= 1'b1;
          tx_cnt  <= 16'd0;
          if (tx_full && !(flow_en && cts_i)) begin
            tx_full <= 1'b0;
            tx_sh   <= tx_hold;
            tx_st   <= S_START;
            uart_tx <= 1'b0;
            tx_cnt  <= div - 16'd1;
          end
        end
        S_START:
          if (tx_tick) begin
            tx_st   <= S_DATA;
            tx_bit  <= 3'd0;
            uart_tx <= tx_sh[0];
          end
        S_DATA:
          if (tx_tick) begin
            tx_bit <= tx_bit + 3'd1;
            if (tx_bit == 3'd7) begin
              if (par != `HSKC_PAR_NONE) begin
                tx_st   <= S_PAR;
                uart_tx <= parity_bit(par, tx_sh);
              end else begin
                tx_st      <= S_STOP;
                tx_stop2nd <= 1'b0;
                uart_tx    <= 1'b1;
              end
            end else begin
              uart_tx <= tx_sh[tx_bit + 3'd1];
            end
          end
        S_PAR:
          if (tx_tick) begin
            tx_st      <= S_STOP;
            tx_stop2nd <= 1'b0;
            uart_tx    <= 1'b1;
          end
        S_STOP:
          if (tx_tick) begin
            if (stop2 && !tx_stop2nd) begin
              tx_stop2nd <= 1'b1;
            end else begin
              tx_st <= S_IDLE;
            end
          end
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  // receiver, samples mid bit, runs independently of transmitter
  reg [2:0]  rx_st;
  reg [15:0] rx_cnt;
  reg [2:0]  rx_bit;
  reg [7:0]  rx_sh;
  reg [7:0]  rx_data;
  reg        rx_valid, rx_perr, rx_ferr, rx_ovr;
  reg        rx_stop2nd;
  wire       rx_tick = (rx_cnt == 16'd0);
  wire       rx_rd, st_clr;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st      <= S_IDLE;
      rx_cnt     <= 16'd0;
      rx_bit     <= 3'd0;
      rx_sh      <= 8'h00;
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
      rx_perr    <= 1'b0;
      rx_ferr    <= 1'b0;
      rx_ovr     <= 1'b0;
      rx_stop2nd <= 1'b0;
      rts_n      <= 1'b1;
    end else begin
      // set wins over clear
      if (rx_rd)
        rx_valid <= 1'b0;
      if (st_clr) begin
        rx_perr <= 1'b0;
        rx_ferr <= 1'b0;
        rx_ovr  <= 1'b0;
      end
      rts_n  <= flow_en ? rx_valid : 1'b0;
      rx_cnt <= rx_tick ? div - 16'd1 : rx_cnt - 16'd1;
      case (rx_st)
        S_IDLE:
          if (!rx_i) begin
            rx_st  <= S_START;
            rx_cnt <= {1'b0, div[15:1]};
          end
        S_START:
          if (rx_tick) begin
            rx_st  <= rx_i ? S_IDLE : S_DATA;
            rx_bit <= 3'd0;
          end
        S_DATA:
          if (rx_tick) begin
            rx_sh  <= {rx_i, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'd1;
            if (rx_bit == 3'd7) begin
              rx_st      <= (par != `HSKC_PAR_NONE) ? S_PAR : S_STOP;
              rx_stop2nd <= 1'b0;
            end
          end
        S_PAR:
          if (rx_tick) begin
            if (rx_i != parity_bit(par, rx_sh))
              rx_perr <= 1'b1;
            rx_st <= S_STOP;
          end
        S_STOP:
          if (rx_tick) begin
            if (!rx_i)
              rx_ferr <= 1'b1;
            if (stop2 && !rx_stop2nd && rx_i) begin
              rx_stop2nd <= 1'b1;
            end else begin
              rx_st    <= S_IDLE;
              rx_data  <= rx_sh;
              rx_valid <= 1'b1;
              if (rx_valid && !rx_rd)
                rx_ovr <= 1'b1;
            end
          end
        default: rx_st <= S_IDLE;
      endcase
    end
  end

  // key pin timing and operating state
  reg [1:0]  state;
  reg [31:0] key_cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= `HSKC_ST_STANDBY;
      key_cnt        <= 32'd0;
      disconnect_req <= 1'b0;
      pairing        <= 1'b0;
    end else begin
      disconnect_req <= 1'b0;
      if (!key_i) begin
        if (key_cnt != 32'hffffffff)
          key_cnt <= key_cnt + 32'd1;
        if (state == `HSKC_ST_STANDBY && key_cnt >= KEY_PAIR - 32'd1)
          pairing <= 1'b1;
      end else begin
        key_cnt <= 32'd0;
        if (key_cnt >= KEY_LONG) begin
          if (state == `HSKC_ST_CONNECTED)
            disconnect_req <= 1'b1;
          else if (state == `HSKC_ST_LOWPOWER)
            state <= `HSKC_ST_STANDBY;
        end
      end
      if (link_up && state != `HSKC_ST_HIBERNATE) begin
        state   <= `HSKC_ST_CONNECTED;
        pairing <= 1'b0;
      end else if (link_down && state == `HSKC_ST_CONNECTED) begin
        state <= `HSKC_ST_STANDBY;
      end else if (hibernate_req) begin
        state   <= `HSKC_ST_HIBERNATE;
        pairing <= 1'b0;
      end else if (lowpower_req && state == `HSKC_ST_STANDBY) begin
        state   <= `HSKC_ST_LOWPOWER;
        pairing <= 1'b0;
      end
    end
  end

  // status pin pattern
  reg [31:0] bl_cnt;
  reg        bl_lvl;
  reg [1:0]  bl_state;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bl_cnt      <= 32'd0;
      bl_lvl      <= 1'b1;
      bl_state    <= `HSKC_ST_STANDBY;
      work_status <= 1'b0;
    end else begin
      bl_state <= state;
      if (state != bl_state) begin
        bl_cnt <= 32'd0;
        bl_lvl <= 1'b1;
      end else if (bl_cnt >= (state == `HSKC_ST_CONNECTED ?
                   (bl_lvl ? CN_ON : CN_OFF) : (bl_lvl ? BL_ON : BL_OFF)) - 32'd1) begin
        bl_cnt <= 32'd0;
        bl_lvl <= ~bl_lvl;
      end else begin
        bl_cnt <= bl_cnt + 32'd1;
      end
      work_status <= (state == `HSKC_ST_LOWPOWER || state == `HSKC_ST_HIBERNATE) ?
                     1'b0 : (state == bl_state) & bl_lvl;
    end
  end

  // apb slave, zero wait states
  wire acc = psel && penable;
  assign tx_wr  = acc && pwrite && paddr == `HSKC_A_TXDATA && !tx_full;
  assign rx_rd  = acc && !pwrite && paddr == `HSKC_A_RXDATA;
  assign st_clr = acc && pwrite && paddr == `HSKC_A_STATUS;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= `HSKC_CTRL_RESET;
      div     <= `HSKC_DIV_STD;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      // writes land at the access edge, where the master sees pready
      if (acc && pwrite && paddr == `HSKC_A_CTRL)
        ctrl <= pwdata[3:0];
      if (acc && pwrite && paddr == `HSKC_A_BAUD && pwdata[15:0] >= `HSKC_DIV_MIN &&
          pwdata[15:0] <= `HSKC_DIV_MAX)
        div <= pwdata[15:0];
      if (psel && !penable) begin
        if (paddr == `HSKC_A_CTRL) begin
          prdata <= {28'h0, ctrl};
        end else if (paddr == `HSKC_A_BAUD) begin
          prdata <= {16'h0, div};
        end else if (paddr == `HSKC_A_STATUS) begin
          prdata <= {26'h0, tx_st != S_IDLE, tx_full, rx_ovr, rx_ferr, rx_perr, rx_valid};
        end else if (paddr == `HSKC_A_TXDATA) begin
          prdata <= {31'h0, tx_full};
        end else if (paddr == `HSKC_A_RXDATA) begin
          prdata <= {24'h0, rx_data};
        end else if (paddr == `HSKC_A_STATE) begin
          prdata <= {29'h0, pairing, state};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // hskc_top

// >>> hskc_props.sv
// port assertions for the host serial and key block
module hskc_props #(
  parameter int MS_CYC = 40000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic uart_tx,
  input wire logic key_n,
  input wire logic link_up,
  input wire logic disconnect_req,
  input wire logic pairing,
  input wire logic work_status
);
  localparam int LONG = 200 * MS_CYC;
  localparam int PAIR = 100 * MS_CYC;
  localparam int HI_MAX = 3000 * MS_CYC + 2;
  int lo_cnt, last_low, hi_cnt;
  // length of the last key press and of the current status high phase
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt   <= 0;
      last_low <= 0;
      hi_cnt   <= 0;
    end else begin
      lo_cnt <= key_n ? 0 : lo_cnt + 1;
      hi_cnt <= work_status ? hi_cnt + 1 : 0;
      if (key_n && lo_cnt != 0) begin
        last_low <= lo_cnt;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_bit_hold: assert property ($changed(uart_tx) |=> $stable(uart_tx) [*7])
    else $error("serial bit too short");
  chk_start_low: assert property ($fell(uart_tx) |-> !uart_tx [*8])
    else $error("start bit too short");
  chk_disc_pulse: assert property (disconnect_req |=> !disconnect_req)
    else $error("disconnect pulse too long");
  chk_disc_cause: assert property (disconnect_req |-> key_n && last_low >= LONG)
    else $error("disconnect without long key press");
  chk_pair_cause: assert property ($rose(pairing) |-> lo_cnt >= PAIR || last_low >= PAIR)
    else $error("pairing without key press");
  chk_pair_excl: assert property (disconnect_req |-> !pairing)
    else $error("pairing outside standby");
  chk_pair_clear: assert property (link_up |-> ##[1:2] !pairing)
    else $error("pairing kept after connect");
  chk_status_high: assert property (hi_cnt <= HI_MAX)
    else $error("status high phase too long");
  cov_disc: cover property (disconnect_req);
  cov_pair: cover property ($rose(pairing));
  cov_frame: cover property ($fell(uart_tx));
endmodule // hskc_props

// >>> hskc_host.sv
// host microcontroller model on the serial lines
module hskc_host #(
  parameter int DIV = 347
) (
  // serial lines
  input  wire logic mclk,
  input  wire logic uart_tx,
  output logic      uart_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial uart_rx = 1'b1;
  // start low, lsb first, parity, stops; DIV cycles a bit
  task automatic send(input logic [7:0] b, input logic [1:0] par, input logic s2);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i < 8; i++) q.push_back(b[i]);
    if (par != 2'h0) q.push_back(^b ^ (par == 2'h1));
    q.push_back(1'b1);
    if (s2) q.push_back(1'b1);
    foreach (q[i]) begin
      uart_rx <= q[i];
      repeat (DIV) @(posedge mclk);
    end
  endtask
  // samples mid-bit, checks start, parity and stop levels
  task automatic recv(output logic [7:0] b, output logic ok, input logic [1:0] par,
                      input logic s2);
    int n;
    n = 0;
    b = 8'h00;
    while (uart_tx !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    repeat (DIV / 2) @(posedge mclk);
    ok = (uart_tx === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge mclk);
      b[i] = uart_tx;
    end
    if (par != 2'h0) begin
      repeat (DIV) @(posedge mclk);
      ok &= (uart_tx === (^b ^ (par == 2'h1)));
    end
    for (int i = 0; i <= int'(s2); i++) begin
      repeat (DIV) @(posedge mclk);
      ok &= (uart_tx === 1'b1);
    end
  endtask
endmodule // hskc_host

// >>> hskc_tb.sv
// self-checking bench for the host serial and key block
`include "hskc_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e, ok, fl, s2;
  logic        uart_rx, uart_tx, cts_n, rts_n, key_n, disconnect_req, pairing, work_status;
  logic        link_up, link_down, lowpower_req, hibernate_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  par;
  logic [7:0]  b1, b2, got;
  logic [7:0]  tx_q[$];
  int          n_errors, n_compared, n_disc;
  int          seed = 42;

  hskc_top #(.MS_CYC(MS)) uut (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .uart_rx, .uart_tx, .cts_n, .rts_n, .key_n, .link_up, .link_down, .lowpower_req,
    .hibernate_req, .disconnect_req, .pairing, .work_status
  );
  hskc_host #(.DIV(`HSKC_DIV_MIN)) host (.mclk, .uart_tx, .uart_rx);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (disconnect_req === 1'b1) n_disc++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) n_errors++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ev(input logic [3:0] k);
    {hibernate_req, lowpower_req, link_down, link_up} <= k;
    @(posedge mclk);
    {hibernate_req, lowpower_req, link_down, link_up} <= 4'h0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic hold(input int cyc);
    key_n <= 1'b0;
    repeat (cyc) @(posedge mclk);
    key_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, cts_n, rst_n} = 5'h0;
    {link_up, link_down, lowpower_req, hibernate_req} = 4'h0;
    {key_n, paddr, pwdata} = {1'b1, 44'h0};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, `HSKC_A_CTRL, 0);
    chk(r, `HSKC_CTRL_RESET);
    apb(1'b1, `HSKC_A_BAUD, `HSKC_DIV_MIN - 1);
    apb(1'b0, `HSKC_A_BAUD, 0);
    chk(r, `HSKC_DIV_STD);
    apb(1'b1, `HSKC_A_BAUD, `HSKC_DIV_MIN);
    apb(1'b0, `HSKC_A_BAUD, 0);
    chk(r, `HSKC_DIV_MIN);
    apb(1'b0, 12'h018, 0);
    chk(e, 1'b1);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      fl = 1'(i % 2);
      par = 2'(i % 3);
      s2 = 1'(i / 3);
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      tx_q.push_back(b1);
      apb(1'b1, `HSKC_A_CTRL, {s2, par, fl});
      cts_n <= 1'b1;
      apb(1'b1, `HSKC_A_TXDATA, b1);
      repeat (20) @(posedge mclk);
      chk(uart_tx, fl);
      cts_n <= 1'b0;
      fork
        host.send(b2, par, s2);
        host.recv(got, ok, par, s2);
      join
      chk(got, tx_q.pop_front());
      chk(ok, 1'b1);
      chk(rts_n, fl);
      apb(1'b0, `HSKC_A_STATUS, 0);
      chk(r[3:0], 4'h1);
      apb(1'b0, `HSKC_A_RXDATA, 0);
      chk(r, b2);
      repeat (2) @(posedge mclk);
      chk(rts_n, 1'b0);
      $display("frame test %0d done", i);
    end
    key_n <= 1'b0;
    repeat (100 * MS + 20) @(posedge mclk);
    chk(pairing, 1'b1);
    ev(4'h1);
    chk(pairing, 1'b0);
    key_n <= 1'b1;
    apb(1'b0, `HSKC_A_STATE, 0);
    chk(r[2:0], 3'h1);
    hold(190 * MS);
    chk(n_disc, 0);
    hold(200 * MS + 5);
    chk(n_disc, 1);
    ev(4'h2);
    ev(4'h4);
    chk(work_status, 1'b0);
    hold(200 * MS + 5);
    apb(1'b0, `HSKC_A_STATE, 0);
    chk(r[2:0], 3'h0);
    chk(work_status, 1'b1);
    ev(4'h8);
    apb(1'b0, `HSKC_A_STATE, 0);
    chk({r[1:0], work_status}, 3'h6);
    $display("key test done");
    report_and_stop();
  end

  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule // testbench

bind hskc_top hskc_props #(.MS_CYC(MS_CYC)) props (
  .mclk, .rst_n, .uart_tx, .key_n, .link_up, .disconnect_req, .pairing, .work_status
);
